// File: hdl/lhcd_bus_if.sv
// host bus between the host end and the decoder end
`timescale 1ns/1ps
interface lhcd_bus_if;
  logic wr_stb;        // one-cycle write strobe
  logic rd_stb;        // one-cycle read strobe
  logic cmd_sel_n;     // 0 command, 1 data
  logic bus16;         // 16-bit bus mode
  logic [15:0] wdata;
  logic [15:0] rdata;  // valid the cycle after rd_stb
  modport dev (input wr_stb, input rd_stb, input cmd_sel_n, input bus16, input wdata,
               output rdata);
  modport host (output wr_stb, output rd_stb, output cmd_sel_n, output bus16, output wdata,
                input rdata);
endinterface : lhcd_bus_if

// File: hdl/lhcd_device.sv
// command decoder end: control registers, ram pointers, ram and status
`timescale 1ns/1ps
module lhcd_device #(
  parameter int WORDS = lhcd_pkg::RAM_WORDS
) (
  input wire logic CLK,
  input wire logic SYS_RST,
  lhcd_bus_if.dev BUS,
  input wire logic [1:0] STRAP_PINS,
  input wire logic [6:0] BIAS_OFFSET,
  input wire logic [1:0] MAKER_BITS,
  output logic [7:0] BIAS_POT,
  output logic [8:0] PANEL_CTRL,
  output logic [4:0] DISP_CTRL,
  output logic [1:0] TEMP_SLOPE,
  output logic [1:0] PUMP_CTRL,
  output logic [8:0] MUX_RATE
);
  typedef enum logic [1:0] {LHCD_ST1 = 2'b01, LHCD_ST2 = 2'b10} lhcd_unused_t;
  logic [6:0] col_ff;
  logic [7:0] row_ff, scroll_ff, bias_ff, scan_end_ff, p_start_ff, p_end_ff, fixed_ff;
  logic [7:0] win_srow_ff, win_erow_ff, pend_ff, wr_mask_ff;
  logic [6:0] win_scol_ff, win_ecol_ff;
  logic [2:0] actl_ff;
  logic [8:0] panel_ff;
  logic [4:0] disp_ff, nvm_ff;
  logic [1:0] temp_ff, pump_ff, stat_idx_ff, byte_ph_ff;
  logic pend_vld_ff, rd_hi_ff;
  logic [15:0] ram [WORDS];
  logic [15:0] rdata_ff, wd_lat_ff, rword;
  logic [7:0] cb;
  logic cmd_wr, dat_wr, word_done, nvm_on;
  logic [15:0] word_in;
  logic [14:0] addr;

  assign cb = BUS.wdata[7:0];
  assign cmd_wr = BUS.wr_stb & ~BUS.cmd_sel_n;
  assign dat_wr = BUS.wr_stb & BUS.cmd_sel_n;
  assign nvm_on = nvm_ff[lhcd_pkg::NVM_EN_BIT];
  assign addr = {row_ff, col_ff};
  assign rword = ram[addr];

  function automatic logic hit(input logic [7:0] b, input logic [7:0] c, input logic [7:0] m);
    return (b & m) == c;
  endfunction : hit

  function automatic logic [7:0] step_row(input logic [7:0] r, input logic down);
    if (down) return (r == 8'h00) ? lhcd_pkg::ROW_WRAP : r - 8'h01;
    return (r == lhcd_pkg::ROW_WRAP) ? 8'h00 : r + 8'h01;
  endfunction : step_row

  // double-byte tracking: the first byte is held, the next command byte is its parameter
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      pend_vld_ff <= 1'b0;
      pend_ff <= 8'h00;
    end else if (cmd_wr) begin
      if (pend_vld_ff) begin
        pend_vld_ff <= 1'b0;
      end else begin
        pend_ff <= cb;
        pend_vld_ff <= (cb == lhcd_pkg::CMD_BIAS) || (cb == lhcd_pkg::CMD_FIXED) ||
                       (cb[7:3] == lhcd_pkg::CMD_SCAN_END[7:3] && cb[2:0] != 3'h0) ||
                       (cb == lhcd_pkg::CMD_NVM_CTL);
      end
    end
  end

  // single-byte control registers
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      actl_ff <= lhcd_pkg::ADDR_CTL_RST;
      panel_ff <= lhcd_pkg::PANEL_RST;
      disp_ff <= lhcd_pkg::DISP_RST;
      temp_ff <= 2'h0;
      pump_ff <= lhcd_pkg::PUMP_RST;
      scroll_ff <= 8'h00;
    end else if (cmd_wr && !pend_vld_ff) begin
      if (hit(cb, lhcd_pkg::CMD_ADDR_CTL, lhcd_pkg::MASK_3B)) actl_ff <= cb[2:0];
      if (hit(cb, lhcd_pkg::CMD_TEMP, lhcd_pkg::MASK_2B)) temp_ff <= cb[1:0];
      if (hit(cb, lhcd_pkg::CMD_PUMP, lhcd_pkg::MASK_2B)) pump_ff <= cb[1:0];
      if (hit(cb, lhcd_pkg::CMD_SCR_LSB, lhcd_pkg::MASK_NIB)) scroll_ff[3:0] <= cb[3:0];
      if (hit(cb, lhcd_pkg::CMD_SCR_MSB, lhcd_pkg::MASK_NIB)) scroll_ff[7:4] <= cb[3:0];
      if (hit(cb, lhcd_pkg::CMD_PARTIAL, lhcd_pkg::MASK_1B)) panel_ff[8] <= cb[0];
      if (hit(cb, lhcd_pkg::CMD_MAPPING, lhcd_pkg::MASK_3B)) panel_ff[2:0] <= cb[2:0];
      if (hit(cb, lhcd_pkg::CMD_COLOR, lhcd_pkg::MASK_2B)) panel_ff[7:6] <= cb[1:0];
      if (hit(cb, lhcd_pkg::CMD_DISP_EN, lhcd_pkg::MASK_3B)) disp_ff[4:2] <= cb[2:0];
    end
  end

  // double-byte parameter registers; the window start column code doubles as wr_mask_ff while nvm is enabled
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      bias_ff <= lhcd_pkg::BIAS_RST;
      fixed_ff <= 8'h00;
      scan_end_ff <= lhcd_pkg::SCAN_END_RST;
      p_start_ff <= 8'h00;
      p_end_ff <= lhcd_pkg::SCAN_END_RST;
      win_scol_ff <= 7'h00;
      win_srow_ff <= 8'h00;
      win_ecol_ff <= lhcd_pkg::COL_MAX;
      win_erow_ff <= lhcd_pkg::ROW_MAX;
      nvm_ff <= lhcd_pkg::NVM_RST;
      wr_mask_ff <= 8'h00;
    end else if (cmd_wr && pend_vld_ff) begin
      unique case (pend_ff)
        lhcd_pkg::CMD_BIAS: bias_ff <= cb;
        lhcd_pkg::CMD_FIXED: fixed_ff <= cb;
        lhcd_pkg::CMD_SCAN_END: scan_end_ff <= cb;
        lhcd_pkg::CMD_PART_START: p_start_ff <= cb;
        lhcd_pkg::CMD_PART_END: p_end_ff <= cb;
        lhcd_pkg::CMD_NVM_CTL: nvm_ff <= cb[4:0];
        lhcd_pkg::CMD_WIN_SCOL: if (!nvm_on) win_scol_ff <= cb[6:0];
                                else wr_mask_ff <= cb;
        lhcd_pkg::CMD_WIN_SROW: if (!nvm_on) win_srow_ff <= cb;
        lhcd_pkg::CMD_WIN_ECOL: if (!nvm_on) win_ecol_ff <= cb[6:0];
        lhcd_pkg::CMD_WIN_EROW: if (!nvm_on) win_erow_ff <= cb;
        default: ;
      endcase
    end
  end

  // colour-mode packing: 8-bit 64k takes two bytes, 16-bit takes one word
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      byte_ph_ff <= 2'h0;
      wd_lat_ff <= 16'h0000;
    end else if (cmd_wr || (BUS.rd_stb && BUS.cmd_sel_n)) begin
      byte_ph_ff <= 2'h0;
    end else if (dat_wr && !BUS.bus16) begin
      wd_lat_ff <= {wd_lat_ff[7:0], cb};
      byte_ph_ff <= (byte_ph_ff == 2'h1) ? 2'h0 : 2'h1;
    end
  end

  // limitation: 4k is stored as 4-4-4 padded on the 16-bit bus only, without dither
  always_comb begin
    word_done = dat_wr && (BUS.bus16 || byte_ph_ff == 2'h1);
    if (BUS.bus16 && panel_ff[7:6] == lhcd_pkg::COLOR_4K)
      word_in = {BUS.wdata[11:8], 1'b0, BUS.wdata[7:4], 2'h0, BUS.wdata[3:0], 1'b0};
    else if (BUS.bus16)
      word_in = BUS.wdata;
    else
      word_in = {wd_lat_ff[7:0], cb};
  end

  always_ff @(posedge CLK) begin
    if (word_done) ram[addr] <= word_in;
  end

  // pointer loads and auto-advance after each full word
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      col_ff <= 7'h00;
      row_ff <= 8'h00;
    end else if (cmd_wr && !pend_vld_ff) begin
      if (hit(cb, lhcd_pkg::CMD_COL_LSB, lhcd_pkg::MASK_NIB)) col_ff[3:0] <= cb[3:0];
      if (hit(cb, lhcd_pkg::CMD_COL_MSB, lhcd_pkg::MASK_3B)) col_ff[6:4] <= cb[2:0];
      if (hit(cb, lhcd_pkg::CMD_ROW_LSB, lhcd_pkg::MASK_NIB)) row_ff[3:0] <= cb[3:0];
      if (hit(cb, lhcd_pkg::CMD_ROW_MSB, lhcd_pkg::MASK_NIB)) row_ff[7:4] <= cb[3:0];
    end else if (word_done || (BUS.rd_stb && BUS.cmd_sel_n && (BUS.bus16 || rd_hi_ff))) begin
      if (!actl_ff[1]) begin
        if (col_ff != lhcd_pkg::COL_MAX) col_ff <= col_ff + 7'h01;
        else if (actl_ff[0]) begin
          col_ff <= 7'h00;
          row_ff <= step_row(row_ff, actl_ff[2]);
        end
      end else begin
        if (row_ff != (actl_ff[2] ? 8'h00 : lhcd_pkg::ROW_WRAP)) begin
          row_ff <= step_row(row_ff, actl_ff[2]);
        end else if (actl_ff[0]) begin
          row_ff <= step_row(row_ff, actl_ff[2]);
          col_ff <= col_ff + 7'h01;
        end
      end
    end
  end

  // read path: status rotation on command reads, ram word on data reads
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      stat_idx_ff <= 2'h0;
      rd_hi_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end else if (BUS.rd_stb && !BUS.cmd_sel_n) begin
      stat_idx_ff <= (stat_idx_ff == 2'h2) ? 2'h0 : stat_idx_ff + 2'h1;
      unique case (stat_idx_ff)
        2'h0: rdata_ff <= {8'h00, disp_ff[4], panel_ff[1], panel_ff[2], actl_ff[0],
                           disp_ff[2], 1'b0, 1'b0, 1'b0};
        2'h1: rdata_ff <= {8'h00, lhcd_pkg::CHIP_VER, BIAS_OFFSET};
        default: rdata_ff <= {8'h00, lhcd_pkg::PRODUCT_CODE, STRAP_PINS, MAKER_BITS};
      endcase
    end else if (BUS.rd_stb) begin
      if (BUS.bus16) rdata_ff <= rword;
      else begin
        rdata_ff <= {8'h00, rd_hi_ff ? rword[7:0] : rword[15:8]};
        rd_hi_ff <= ~rd_hi_ff;
      end
    end else if (BUS.wr_stb && BUS.cmd_sel_n) begin
      stat_idx_ff <= 2'h0; // data phase ends the status transaction
      rd_hi_ff <= 1'b0;
    end
  end

  // mux rate follows partial display selection
  always_ff @(posedge CLK) begin
    if (SYS_RST) MUX_RATE <= 9'h0A0;
    else if (panel_ff[8])
      MUX_RATE <= 9'(p_end_ff - p_start_ff) + 9'h001 +
                  (panel_ff[0] ? 9'({fixed_ff[7:4], 1'b0} + {fixed_ff[3:0], 1'b0}) : 9'h000);
    else MUX_RATE <= 9'(scan_end_ff) + 9'h001;
  end

  assign BUS.rdata = rdata_ff;
  assign BIAS_POT = bias_ff;
  assign PANEL_CTRL = panel_ff;
  assign DISP_CTRL = disp_ff;
  assign TEMP_SLOPE = temp_ff;
  assign PUMP_CTRL = pump_ff;
endmodule : lhcd_device

// File: hdl/lhcd_host.sv
// host end: turns user requests into single bus cycles
`timescale 1ns/1ps
module lhcd_host (
  input wire logic CLK,
  input wire logic SYS_RST,
  lhcd_bus_if.host BUS,
  input wire logic REQ_VALID,
  input wire logic REQ_READ,
  input wire logic REQ_DATA,
  input wire logic REQ_WIDE,
  input wire logic [15:0] REQ_WDATA,
  output logic RSP_VALID,
  output logic [15:0] RSP_RDATA
);
  logic rd_pend_ff;
  logic [15:0] rsp_ff;

  // only defined codes are expected from the user; the full word goes out so the
  // decoder alone decides which byte a command uses
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      BUS.wr_stb <= 1'b0;
      BUS.rd_stb <= 1'b0;
      BUS.cmd_sel_n <= 1'b0;
      BUS.bus16 <= 1'b0;
      BUS.wdata <= 16'h0000;
    end else begin
      BUS.wr_stb <= REQ_VALID & ~REQ_READ;
      BUS.rd_stb <= REQ_VALID & REQ_READ;
      if (REQ_VALID) begin
        BUS.cmd_sel_n <= REQ_DATA;
        BUS.bus16 <= REQ_WIDE;
        BUS.wdata <= REQ_WDATA;
      end
    end
  end

  // answer is captured one cycle after the read strobe
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rd_pend_ff <= 1'b0;
      rsp_ff <= 16'h0000;
    end else begin
      rd_pend_ff <= BUS.rd_stb;
      if (rd_pend_ff) rsp_ff <= BUS.rdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) RSP_VALID <= 1'b0;
    else RSP_VALID <= rd_pend_ff;
  end

  assign RSP_RDATA = rsp_ff;
endmodule : lhcd_host

// File: hdl/lhcd_pkg.sv
// shared constants for the lcd host command decoder
package lhcd_pkg;
  localparam logic [7:0] CMD_COL_LSB = 8'h00;  // 0000_xxxx
  localparam logic [7:0] CMD_COL_MSB = 8'h10;  // 0001_0xxx
  localparam logic [7:0] CMD_TEMP = 8'h24;     // 0010_01xx
  localparam logic [7:0] CMD_PUMP = 8'h28;     // 0010_10xx
  localparam logic [7:0] CMD_SCR_LSB = 8'h40;
  localparam logic [7:0] CMD_SCR_MSB = 8'h50;
  localparam logic [7:0] CMD_ROW_LSB = 8'h60;
  localparam logic [7:0] CMD_ROW_MSB = 8'h70;
  localparam logic [7:0] CMD_BIAS = 8'h81;
  localparam logic [7:0] CMD_PARTIAL = 8'h84;  // 1000_010x
  localparam logic [7:0] CMD_ADDR_CTL = 8'h88; // 1000_1xxx
  localparam logic [7:0] CMD_FIXED = 8'h90;
  localparam logic [7:0] CMD_DISP_EN = 8'hA8;  // 1010_1xxx
  localparam logic [7:0] CMD_MAPPING = 8'hC0;  // 1100_0xxx
  localparam logic [7:0] CMD_COLOR = 8'hD4;    // 1101_01xx
  localparam logic [7:0] CMD_SCAN_END = 8'hF1;
  localparam logic [7:0] CMD_PART_START = 8'hF2;
  localparam logic [7:0] CMD_PART_END = 8'hF3;
  localparam logic [7:0] CMD_WIN_SCOL = 8'hF4;
  localparam logic [7:0] CMD_WIN_SROW = 8'hF5;
  localparam logic [7:0] CMD_WIN_ECOL = 8'hF6;
  localparam logic [7:0] CMD_WIN_EROW = 8'hF7;
  localparam logic [7:0] CMD_NVM_CTL = 8'hB8;
  localparam logic [7:0] MASK_NIB = 8'hF0;
  localparam logic [7:0] MASK_3B = 8'hF8;
  localparam logic [7:0] MASK_2B = 8'hFC;
  localparam logic [7:0] MASK_1B = 8'hFE;
  localparam logic [7:0] BIAS_RST = 8'h40;
  localparam logic [2:0] ADDR_CTL_RST = 3'h1;
  localparam logic [8:0] PANEL_RST = 9'h090;
  localparam logic [4:0] DISP_RST = 5'h18;
  localparam logic [1:0] PUMP_RST = 2'h2;
  localparam logic [7:0] SCAN_END_RST = 8'h9F;
  localparam logic [6:0] COL_MAX = 7'h7F;
  localparam logic [7:0] ROW_MAX = 8'h9F;
  localparam logic [7:0] ROW_WRAP = 8'h7F;  // row wrap end as printed
  localparam int NVM_EN_BIT = 3;
  localparam logic [4:0] NVM_RST = 5'h10;
  localparam logic [3:0] PRODUCT_CODE = 4'h5;  // arbitrary value
  localparam logic CHIP_VER = 1'b0;            // arbitrary value
  localparam logic [1:0] COLOR_4K = 2'h1;
  localparam int RAM_WORDS = 20480;            // 160 rows x 128 columns
endpackage : lhcd_pkg

// File: verification/lhcd_bus_asserts.sv
// bus checks between the host end and the decoder end
`timescale 1ns/1ps
module lhcd_bus_asserts (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic cmd_sel_n,
  input wire logic bus16,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata
);
  logic [1:0] rot_ff;
  logic [4:0] flg_ff;  // green, mirror x, mirror y, wrap, display
  logic [7:0] op;
  assign op = wdata[7:0];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // status rotation; a data write starts it over
  always_ff @(posedge CLK) begin
    if (SYS_RST || (wr_stb && cmd_sel_n)) rot_ff <= 2'h0;
    else if (rd_stb && !cmd_sel_n) rot_ff <= (rot_ff == 2'h2) ? 2'h0 : rot_ff + 2'h1;
  end
  // flag shadow; no parameter byte is ever sent with these codes, so no pending state
  always_ff @(posedge CLK) begin
    if (SYS_RST) flg_ff <= 5'h12;
    else if (wr_stb && !cmd_sel_n) begin
      if (op[7:3] == 5'h11) flg_ff[1] <= op[0];
      if (op[7:3] == 5'h18) flg_ff[3:2] <= {op[1], op[2]};
      if (op[7:3] == 5'h15) {flg_ff[4], flg_ff[0]} <= {op[2], op[0]};
    end
  end
  sequence stat_rd;
    rd_stb && !cmd_sel_n;
  endsequence
  sequence three_rd;
    (rd_stb && !cmd_sel_n && rot_ff == 2'h0) ##1 stat_rd ##1 stat_rd;
  endsequence
  stb_excl_a: assert property (!(wr_stb && rd_stb))
    else $error("read and write strobe together");
  rdata_hold_a: assert property (!$past(rd_stb) |-> $stable(rdata))
    else $error("read data moved without a read");
  wrap_flag_a: assert property (
    stat_rd ##0 rot_ff == 2'h0 |=> rdata[4] == $past(flg_ff[1]))
    else $error("wrap flag wrong");
  status_one_a: assert property (
    stat_rd ##0 rot_ff == 2'h0 |=> rdata[7:3] == $past(flg_ff))
    else $error("first status byte wrong");
  version_bit_a: assert property (
    stat_rd ##0 rot_ff == 2'h1 |=> rdata[7] == lhcd_pkg::CHIP_VER)
    else $error("version bit wrong");
  product_code_a: assert property (
    stat_rd ##0 rot_ff == 2'h2 |=> rdata[7:4] == lhcd_pkg::PRODUCT_CODE)
    else $error("product code wrong");
  status_walk_a: assert property (three_rd |=> rdata[7:4] == lhcd_pkg::PRODUCT_CODE)
    else $error("status rotation wrong");
  // put and get in the bench leave one idle cycle between a data write and the next read
  restart_rot_a: assert property (
    (wr_stb && cmd_sel_n) ##1 !rd_stb ##1 stat_rd |=> rdata[7:3] == $past(flg_ff))
    else $error("rotation not restarted");
endmodule : lhcd_bus_asserts

// File: verification/testbench.sv
// self-checking bench: host end and decoder end back to back
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic req_valid = 1'b0, req_read = 1'b0, req_data = 1'b0, req_wide = 1'b0;
  logic [15:0] req_wdata = 16'h0000;
  logic rsp_valid;
  logic [15:0] rsp_rdata;
  logic [8:0] panel_ctrl, mux_rate;
  logic [7:0] bias_pot;
  logic [4:0] disp_ctrl;
  logic [1:0] temp_slope, pump_ctrl;
  logic [15:0] got [4];
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  lhcd_bus_if bus ();
  lhcd_host i_lhcd_host (.CLK(clk), .SYS_RST(sys_rst), .BUS(bus), .REQ_VALID(req_valid),
    .REQ_READ(req_read), .REQ_DATA(req_data), .REQ_WIDE(req_wide), .REQ_WDATA(req_wdata),
    .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata));
  // status inputs held at known values
  lhcd_device i_lhcd_device (.CLK(clk), .SYS_RST(sys_rst), .BUS(bus), .STRAP_PINS(2'h2),
    .BIAS_OFFSET(7'h35), .MAKER_BITS(2'h1), .BIAS_POT(bias_pot), .PANEL_CTRL(panel_ctrl),
    .DISP_CTRL(disp_ctrl), .TEMP_SLOPE(temp_slope), .PUMP_CTRL(pump_ctrl), .MUX_RATE(mux_rate));
  lhcd_bus_asserts i_lhcd_bus_asserts (.CLK(clk), .SYS_RST(sys_rst), .wr_stb(bus.wr_stb),
    .rd_stb(bus.rd_stb), .cmd_sel_n(bus.cmd_sel_n), .bus16(bus.bus16), .wdata(bus.wdata),
    .rdata(bus.rdata));
  always #2.5 clk = ~clk;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  task automatic check(input logic [15:0] a, input logic [15:0] e);
    num_checks++;
    if (a !== e) begin
      fail_count++;
      $display("wrong value at %0t: got %h want %h", $time, a, e);
    end
  endtask : check
  // request fields launch just after the edge and stand until the next one
  task automatic drive(input logic rd, input logic dt, input logic wd, input logic [15:0] v);
    @(posedge clk);
    #1;
    req_read = rd;
    req_data = dt;
    req_wide = wd;
    req_wdata = v;
    req_valid = 1'b1;
  endtask : drive
  task automatic put(input logic dt, input logic [15:0] v, input logic wd = 1'b1);
    drive(1'b0, dt, wd, v);
    @(posedge clk);
    #1;
    req_valid = 1'b0;
  endtask : put
  // junk upper byte: only the low byte may be decoded
  task automatic cmd(input logic [7:0] b);
    put(1'b0, {8'hA5, b});
  endtask : cmd
  task automatic at(input logic [7:0] r, input logic [6:0] c);
    cmd({4'h6, r[3:0]});
    cmd({4'h7, r[7:4]});
    cmd({4'h0, c[3:0]});
    cmd({5'h02, c[6:4]});
  endtask : at
  // back-to-back reads, answers gathered as they return
  task automatic get(input int n, input logic dt, input logic wd);
    int k;
    k = 0;
    fork
      begin
        for (int i = 0; i < n; i++) drive(1'b1, dt, wd, 16'h0000);
        @(posedge clk);
        #1;
        req_valid = 1'b0;
      end
      for (int t = 0; t < n + 8 && k < n; t++) begin
        @(posedge clk);
        #1;
        if (rsp_valid === 1'b1) begin
          got[k] = rsp_rdata;
          k++;
        end
      end
    join
    check(16'(k), 16'(n));
  endtask : get
  task automatic idle();
    repeat (4) @(posedge clk);
    #1;
  endtask : idle
  // two writes from (r,c); the second must land at (r2,c2)
  task automatic pair(input logic [7:0] ac, r, r2, input logic [6:0] c, c2);
    cmd(ac);
    at(r, c);
    put(1'b1, 16'h1234);
    put(1'b1, {r2, 1'b1, c2});
    at(r2, c2);
    get(1, 1'b1, 1'b1);
    check(got[0], {r2, 1'b1, c2});
  endtask : pair
  task automatic t_reset();
    check(16'(bias_pot), 16'h0040);
    check(16'(panel_ctrl), 16'h0090);
    check(16'(disp_ctrl), 16'h0018);
    check(16'(pump_ctrl), 16'h0002);
    check(16'(mux_rate), 16'h00A0);
    $display("reset values done");
  endtask : t_reset
  task automatic t_cmds();
    cmd(8'h81);
    cmd(8'h27);
    idle();
    check(16'(bias_pot), 16'h0027);
    check(16'(temp_slope), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      cmd({6'h09, 2'(i)});
      idle();
      check(16'(temp_slope), 16'(i));
    end
    cmd(8'h2B);
    cmd(8'hF2);
    cmd(8'h10);
    cmd(8'h85);
    idle();
    check(16'(pump_ctrl), 16'h0003);
    check(16'(mux_rate), 16'h0090);
    cmd(8'h84);
    cmd(8'hF1);
    cmd(8'h4F);
    idle();
    check(16'(mux_rate), 16'h0050);
    // fixed lines top 2 and bottom 1 add twice their sum when shown
    cmd(8'hC1);
    cmd(8'h90);
    cmd(8'h21);
    cmd(8'h85);
    idle();
    check(16'(mux_rate), 16'h0096);
    cmd(8'h84);
    $display("command loads done");
  endtask : t_cmds
  task automatic t_status();
    cmd(8'h88);
    cmd(8'hC6);
    put(1'b1, 16'h0000);
    get(4, 1'b0, 1'b1);
    check(16'(got[0][7:3]), 16'h001C);
    check(16'(got[1][7:0]), 16'({lhcd_pkg::CHIP_VER, 7'h35}));
    check(16'(got[2][7:0]), 16'({lhcd_pkg::PRODUCT_CODE, 4'h9}));
    check(16'(got[3][7:3]), 16'h001C);
    // rotation stands mid-way here; a data write must start it over
    put(1'b1, 16'h0000);
    get(1, 1'b0, 1'b1);
    check(16'(got[0][7:3]), 16'h001C);
    $display("status reads done");
  endtask : t_status
  task automatic t_ram();
    cmd(8'hC0);
    pair(8'h89, 8'h05, 8'h06, 7'h7F, 7'h00);
    at(8'h06, 7'h00);
    get(2, 1'b1, 1'b0);
    check(16'(got[0][7:0]), 16'h0006);
    check(16'(got[1][7:0]), 16'h0080);
    pair(8'h88, 8'h02, 8'h02, 7'h7F, 7'h7F);
    pair(8'h8D, 8'h00, 8'h7F, 7'h7F, 7'h00);
    pair(8'h8B, 8'h0A, 8'h0B, 7'h14, 7'h14);
    // two 8-bit writes form one word high byte first, then a 4k word padded 4-4-4
    cmd(8'h88);
    at(8'h03, 7'h10);
    put(1'b1, 16'h00AB, 1'b0);
    put(1'b1, 16'h00CD, 1'b0);
    cmd(8'hD5);
    put(1'b1, 16'h0ABC);
    cmd(8'hD6);
    at(8'h03, 7'h10);
    get(2, 1'b1, 1'b1);
    check(got[0], 16'hABCD);
    check(got[1], 16'hA598);
    $display("ram access done");
  endtask : t_ram
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    t_reset();
    t_cmds();
    t_status();
    t_ram();
    end_of_test();
  end
endmodule : testbench
